// [rtl/cxh_regs.svh]
// Constants for the CAN transceiver host pin interface.
`ifndef CXH_REGS_SVH
`define CXH_REGS_SVH
`define CXH_CLK_NS 100
`define CXH_SPI_MIN_PERIOD_NS 250
`define CXH_SCK_HALF_CYC 4
`define CXH_BYTE_BITS 8
`define CXH_ECHO_BYTES 2
`define CXH_CMD_BYTES 3
`define CXH_CNT_W 5
`define CXH_AUX_N 3
`define CXH_AUX_RX2 0
`define CXH_AUX_TX2 1
`define CXH_AUX_WAKE 2
`define CXH_OP_AUX_OUT 8'h01
`define CXH_OP_AUX_OE 8'h02
`define CXH_OP_AUX_READ 8'h03
`define CXH_OP_SECOND_PAIR 8'h04
`define CXH_OP_WAKE_EN 8'h05
`endif

// [rtl/cxh_pkg.sv]
// Types for the CAN transceiver host pin interface.
package cxh_pkg;
  typedef enum logic [2:0] {
    CXH_MODE_NORMAL = 3'b000,
    CXH_MODE_STANDBY = 3'b001,
    CXH_MODE_SLEEP = 3'b010,
    CXH_MODE_RX_ONLY = 3'b011,
    CXH_MODE_OTHER = 3'b100
  } cxh_mode_t;
  typedef enum logic [1:0] {
    CXH_H_IDLE = 2'b00,
    CXH_H_LOW = 2'b01,
    CXH_H_HIGH = 2'b10,
    CXH_H_DONE = 2'b11
  } cxh_hstate_t;
endpackage

// [rtl/cxh_if.sv]
// Pin-level interface between the transceiver and its host.
`timescale 1ns/1ps
interface cxh_if;
  logic port_select_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic txd;
  logic rxd;
  logic tx_enable_n_host_oe;
  logic [2:0] aux_dev_o;
  logic [2:0] aux_dev_oe;
  logic [2:0] aux_host_o;
  logic [2:0] aux_host_oe;
  logic [2:0] aux_level;
  logic tx_enable_n;
  // Open-drain transmit enable with the device weak pull-up.
  assign tx_enable_n = tx_enable_n_host_oe ? 1'b0 : 1'b1;
  modport dev (input port_select_n, input sck, input sdi, output sdo, output sdo_oe, input txd, output rxd,
    input tx_enable_n, output aux_dev_o, output aux_dev_oe, input aux_level);
  modport host (output port_select_n, output sck, output sdi, input sdo, input sdo_oe, output txd, input rxd,
    output tx_enable_n_host_oe, output aux_host_o, output aux_host_oe, input aux_level);
endinterface

// [rtl/cxh_sync.sv]
// Two-flop synchroniser with keeper for pin inputs.
`timescale 1ns/1ps
module cxh_sync #(parameter int W = 1) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] driven_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] keep_q;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
  // Each bit keeps its last driven level when released.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_keep
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          keep_q[i] <= 1'b0;
        end else if (driven_in[i]) begin
          keep_q[i] <= sync_q[i];
        end
      end
    end
  endgenerate
  assign level_out = keep_q;
endmodule // cxh_sync

// [rtl/cxh_dev.sv]
// Transceiver end: serial port, transmit gating, stream pass-through, aux pins.
// Operation
// - Host serial clock at most 4 Mbit/s.
// - Port selected only while select input low.
// - Serial inputs pull toward applied level.
// - Undriven serial inputs keep last level.
// - Host gives transceiver its own select line.
// - No daisy chain; input past the second byte never forwarded.
// - Streams connect to host CAN controller.
// - Transmitter off while transmit enable high.
// - Pull-up on enable in four modes.
// - Other modes may pull enable low.
// - Host drives enable low, open drain.
// - Standby and sleep force transmitter off.
// - Host drives enable low only when active.
// - Three aux pins controlled over serial port.
// - Aux pins may carry second stream pair.
// - Aux pin may wake the host.
// - Aux functions need proper mode and supply; the second transmit stream into the transmitter is not gated by them.
// - Aux pins keep last level when undriven.
// - First fifteen received bits echoed out, one bit behind.
`timescale 1ns/1ps
module cxh_dev (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  cxh_if.dev pins,
  input wire cxh_pkg::cxh_mode_t mode_in,
  input wire logic io_supply_in,
  input wire logic [2:0] serial_drive_in,
  input wire logic [2:0] aux_drive_in,
  input wire logic bus_rx_in,
  output logic tx_active_out,
  output logic bus_tx_out,
  output logic [2:0] serial_keep_out,
  output logic tx_enable_n_pull_up_out,
  output logic tx_enable_n_pull_low_out,
  output logic second_tx_stream_out,
  output logic host_wake_out,
  output logic [7:0] last_op_out,
  output logic [7:0] last_data_out
);
  import cxh_pkg::*;
  `include "cxh_regs.svh"

  // ----------------------------------------
  // Pin synchronisers and keepers
  // ----------------------------------------
  logic [2:0] ser_lvl;
  logic [2:0] aux_lvl;
  logic [2:0] misc_lvl;
  cxh_sync #(.W(3)) u_ser (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .pin_in({pins.port_select_n, pins.sck, pins.sdi}), .driven_in(serial_drive_in), .level_out(ser_lvl));
  cxh_sync #(.W(3)) u_aux (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .pin_in(pins.aux_level), .driven_in(aux_drive_in), .level_out(aux_lvl));
  cxh_sync #(.W(3)) u_misc (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .pin_in({pins.tx_enable_n, pins.txd, io_supply_in}), .driven_in(3'b111), .level_out(misc_lvl));
  logic sel_n;
  logic sck_l;
  logic sdi_l;
  assign sel_n = ser_lvl[2];
  assign sck_l = ser_lvl[1];
  assign sdi_l = ser_lvl[0];
  assign serial_keep_out = ser_lvl;

  function automatic logic low_power_ok(input cxh_mode_t m);
    low_power_ok = (m == CXH_MODE_NORMAL) || (m == CXH_MODE_STANDBY) || (m == CXH_MODE_SLEEP)
      || (m == CXH_MODE_RX_ONLY);
  endfunction

  // ----------------------------------------
  // Serial port shift and echo
  // ----------------------------------------
  logic sck_q;
  logic [7:0] sh_q;
  logic [7:0] echo_q;
  logic [`CXH_CNT_W-1:0] bit_q;
  logic [7:0] op_q;
  logic [7:0] data_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic rise;
  logic fall;
  logic [7:0] sh_d;
  assign rise = !sck_q && sck_l;
  assign fall = sck_q && !sck_l;
  assign sh_d = {sh_q[6:0], sdi_l};
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck_l;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sh_q <= 8'h00;
      bit_q <= '0;
      op_q <= 8'h00;
      data_q <= 8'h00;
    end else if (sel_n) begin
      bit_q <= '0;
    end else if (rise) begin
      sh_q <= sh_d;
      if (bit_q < 5'(`CXH_CMD_BYTES * `CXH_BYTE_BITS)) begin
        bit_q <= bit_q + 5'd1;
      end
      if (bit_q == 5'(`CXH_BYTE_BITS - 1)) begin
        op_q <= sh_d;
      end
      if (bit_q == 5'(2 * `CXH_BYTE_BITS - 1)) begin
        data_q <= sh_d;
      end
    end
  end
  // Echo the current byte one bit behind; third byte returns aux state, never raw input.
  // The aux byte is latched once at the end of the second byte and held to the end of the frame.
  logic [`CXH_CNT_W-1:0] out_idx;
  assign out_idx = 5'(`CXH_CMD_BYTES * `CXH_BYTE_BITS - 1) - bit_q;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      echo_q <= 8'h00;
      sdo_q <= 1'b0;
    end else if (sel_n) begin
      echo_q <= 8'h00;
    end else if (rise) begin
      if (bit_q < 5'(`CXH_ECHO_BYTES * `CXH_BYTE_BITS - 1)) begin
        echo_q <= sh_d;
      end else if (bit_q == 5'(`CXH_ECHO_BYTES * `CXH_BYTE_BITS - 1)) begin
        echo_q <= {5'd0, aux_lvl};
      end
    end else if (fall) begin
      if (bit_q < 5'(`CXH_ECHO_BYTES * `CXH_BYTE_BITS)) begin
        sdo_q <= echo_q[0];
      end else if (out_idx < 5'(`CXH_BYTE_BITS)) begin
        sdo_q <= echo_q[out_idx[2:0]];
      end else begin
        sdo_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= !sel_n && misc_lvl[0];
    end
  end
  assign pins.sdo = sdo_q;
  assign pins.sdo_oe = sdo_oe_q;
  assign last_op_out = op_q;
  assign last_data_out = data_q;

  // ----------------------------------------
  // Aux pin control registers
  // ----------------------------------------
  logic [2:0] aux_out_q;
  logic [2:0] aux_oe_q;
  logic second_q;
  logic wake_en_q;
  logic commit;
  assign commit = !sel_n && rise && (bit_q == 5'(2 * `CXH_BYTE_BITS - 1));
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aux_out_q <= 3'h0;
      aux_oe_q <= 3'h0;
      second_q <= 1'b0;
      wake_en_q <= 1'b0;
    end else if (commit) begin
      unique case (op_q)
        `CXH_OP_AUX_OUT: aux_out_q <= sh_d[2:0];
        `CXH_OP_AUX_OE: aux_oe_q <= sh_d[2:0];
        `CXH_OP_SECOND_PAIR: second_q <= sh_d[0];
        `CXH_OP_WAKE_EN: wake_en_q <= sh_d[0];
        default: second_q <= second_q;
      endcase
    end
  end
  logic aux_ok;
  assign aux_ok = low_power_ok(mode_in) && misc_lvl[0];
  logic [2:0] aux_o_d;
  logic [2:0] aux_oe_d;
  always_comb begin
    aux_o_d = aux_out_q;
    aux_oe_d = aux_ok ? aux_oe_q : 3'b000;
    if (aux_ok && second_q) begin
      aux_o_d[`CXH_AUX_RX2] = bus_rx_in;
      aux_oe_d[`CXH_AUX_RX2] = 1'b1;
      aux_oe_d[`CXH_AUX_TX2] = 1'b0;
    end
  end
  logic [2:0] aux_o_q;
  logic [2:0] aux_oe_q2;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aux_o_q <= 3'h0;
      aux_oe_q2 <= 3'h0;
    end else begin
      aux_o_q <= aux_o_d;
      aux_oe_q2 <= aux_oe_d;
    end
  end
  assign pins.aux_dev_o = aux_o_q;
  assign pins.aux_dev_oe = aux_oe_q2;
  assign second_tx_stream_out = aux_lvl[`CXH_AUX_TX2];
  assign host_wake_out = aux_ok && wake_en_q && aux_lvl[`CXH_AUX_WAKE];

  // ----------------------------------------
  // Transmitter gating and stream pass-through
  // ----------------------------------------
  logic tx_en;
  assign tx_en = !misc_lvl[2] && (mode_in != CXH_MODE_STANDBY) && (mode_in != CXH_MODE_SLEEP);
  assign tx_enable_n_pull_up_out = low_power_ok(mode_in);
  assign tx_enable_n_pull_low_out = !low_power_ok(mode_in) && misc_lvl[0];
  assign tx_active_out = tx_en;
  logic bus_tx_q;
  logic rxd_q;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_tx_q <= 1'b1;
      rxd_q <= 1'b1;
    end else begin
      bus_tx_q <= tx_en ? (misc_lvl[1] & (second_q ? aux_lvl[`CXH_AUX_TX2] : 1'b1)) : 1'b1;
      rxd_q <= bus_rx_in;
    end
  end
  assign bus_tx_out = bus_tx_q;
  assign pins.rxd = rxd_q;
endmodule // cxh_dev

// [rtl/cxh_host.sv]
// Host end: serial master, stream pass-through and transmit enable drive.
`timescale 1ns/1ps
module cxh_host (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  cxh_if.host pins,
  input wire logic start_in,
  input wire logic [7:0] op_in,
  input wire logic [7:0] data_in,
  input wire logic can_tx_in,
  input wire logic tx_request_in,
  input wire logic dev_active_in,
  input wire logic [2:0] aux_o_in,
  input wire logic [2:0] aux_oe_in,
  output logic busy_out,
  output logic done_out,
  output logic echo_ok_out,
  output logic [7:0] read_out,
  output logic can_rx_out
);
  import cxh_pkg::*;
  `include "cxh_regs.svh"
  cxh_hstate_t st_q;
  logic [23:0] tx_q;
  logic [23:0] rx_q;
  logic [15:0] sent_q;
  logic [`CXH_CNT_W-1:0] bit_q;
  logic [2:0] div_q;
  logic sdo_m;
  logic sdo_s;
  logic rxd_m;
  logic rxd_s;
  logic tick;
  assign tick = div_q == 3'(`CXH_SCK_HALF_CYC - 1);
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sdo_m <= 1'b0;
      sdo_s <= 1'b0;
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      sdo_m <= pins.sdo & pins.sdo_oe;
      sdo_s <= sdo_m;
      rxd_m <= pins.rxd;
      rxd_s <= rxd_m;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_q <= 3'h0_0;
    end else if (st_q == CXH_H_IDLE || tick) begin
      div_q <= 3'h0_0;
    end else begin
      div_q <= div_q + 3'd1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= CXH_H_IDLE;
      tx_q <= '0;
      rx_q <= '0;
      sent_q <= '0;
      bit_q <= '0;
    end else begin
      unique case (st_q)
        CXH_H_IDLE: if (start_in) begin
          tx_q <= {op_in, data_in, 8'h00};
          sent_q <= {op_in, data_in};
          bit_q <= '0;
          st_q <= CXH_H_LOW;
        end
        CXH_H_LOW: if (tick) begin
          st_q <= CXH_H_HIGH;
        end
        // The answer is sampled at the end of the high phase, after the device's latency has passed.
        CXH_H_HIGH: if (tick) begin
          rx_q <= {rx_q[22:0], sdo_s};
          tx_q <= {tx_q[22:0], 1'b0};
          bit_q <= bit_q + 5'd1;
          st_q <= (bit_q == 5'(`CXH_CMD_BYTES * `CXH_BYTE_BITS - 1)) ? CXH_H_DONE : CXH_H_LOW;
        end
        CXH_H_DONE: st_q <= CXH_H_IDLE;
      endcase
    end
  end
  assign pins.port_select_n = (st_q == CXH_H_IDLE);
  assign pins.sck = (st_q == CXH_H_HIGH);
  assign pins.sdi = tx_q[23];
  assign busy_out = (st_q != CXH_H_IDLE);
  assign done_out = (st_q == CXH_H_DONE);
  // The echo runs one bit behind, so slots one to fifteen carry the first fifteen bits sent.
  assign echo_ok_out = (rx_q[22:8] == sent_q[15:1]);
  assign read_out = rx_q[7:0];
  assign pins.txd = can_tx_in;
  assign can_rx_out = rxd_s;
  assign pins.tx_enable_n_host_oe = tx_request_in && dev_active_in;
  assign pins.aux_host_o = aux_o_in;
  assign pins.aux_host_oe = aux_oe_in;
endmodule // cxh_host

// [tb/cxh_asserts.sv]
// Concurrent checks on the serial port wires between the two ends.
`timescale 1ns/1ps
module cxh_asserts (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic port_select_n,
  input wire logic sck,
  input wire logic sdo_oe
);
  int n_rise;
  int n_low;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // ----------------
  // Frame counters
  // ----------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      n_rise <= 0;
      n_low <= 0;
    end else if (port_select_n) begin
      n_rise <= 0;
      n_low <= 0;
    end else begin
      n_rise <= n_rise + ($rose(sck) ? 1 : 0);
      n_low <= n_low + 1;
    end
  end
  // ----------------
  // Properties
  // ----------------
  sequence s_sck_high;
    sck [*4];
  endsequence
  sequence s_sck_low;
    !sck [*4];
  endsequence
  property p_sck_in_frame;
    $rose(sck) |-> !port_select_n;
  endproperty
  property p_sck_high;
    $rose(sck) |-> s_sck_high ##1 !sck;
  endproperty
  property p_sck_low;
    $fell(sck) |-> s_sck_low;
  endproperty
  property p_bits;
    $rose(port_select_n) |-> n_rise == 24;
  endproperty
  property p_frame_len;
    $rose(port_select_n) |-> n_low inside {[190:200]};
  endproperty
  property p_select_hold;
    $fell(port_select_n) |-> !port_select_n [*8];
  endproperty
  property p_sdo_release;
    $rose(port_select_n) |-> ##[0:5] !sdo_oe;
  endproperty
  property p_sdo_quiet;
    port_select_n [*8] |-> !sdo_oe;
  endproperty
  a_sck_in_frame:
    assert property (p_sck_in_frame) else $error("serial clock edge while deselected");
  a_sck_high:
    assert property (p_sck_high) else $error("serial clock high phase wrong");
  a_sck_low:
    assert property (p_sck_low) else $error("serial clock low phase too short");
  a_bits:
    assert property (p_bits) else $error("frame bit count wrong");
  a_frame_len:
    assert property (p_frame_len) else $error("frame length wrong");
  a_select_hold:
    assert property (p_select_hold) else $error("select released early");
  a_sdo_release:
    assert property (p_sdo_release) else $error("data output kept after deselect");
  a_sdo_quiet:
    assert property (p_sdo_quiet) else $error("data output driven while deselected");
endmodule // cxh_asserts

// [tb/can_xcvr_host_pin_interface_tb.sv]
// Bench joining both ends of the host pin interface.
`timescale 1ns/1ps
module can_xcvr_host_pin_interface_tb;
  import cxh_pkg::*;
  logic clk_sys_in = 0, rstn_in = 0, start_in = 0, can_tx_in = 1, tx_req = 0, dev_act = 1, bus_rx = 1, sup = 1;
  logic [7:0] op = 0, dat = 0;
  logic [2:0] ho = 0, hoe = 0, sdrv = 3'h7, keep = 0, exp3;
  cxh_mode_t mode = CXH_MODE_NORMAL;
  logic tx_act, btx, pu, pl, tx2, wake, busy, done, eok, crx;
  logic [2:0] skeep;
  logic [7:0] lop, ldat, rd;
  logic [15:0] rnd = 16'h491d;
  int fails = 0, n_checks = 0, cyc = 0;
  int exp_q[$];
  cxh_if pins ();
  cxh_dev i_cxh_dev (.clk_sys_in, .rstn_in, .pins(pins.dev), .mode_in(mode), .io_supply_in(sup),
    .serial_drive_in(sdrv), .aux_drive_in(hoe), .bus_rx_in(bus_rx), .tx_active_out(tx_act), .bus_tx_out(btx),
    .serial_keep_out(skeep), .tx_enable_n_pull_up_out(pu), .tx_enable_n_pull_low_out(pl),
    .second_tx_stream_out(tx2), .host_wake_out(wake), .last_op_out(lop), .last_data_out(ldat));
  cxh_host i_cxh_host (.clk_sys_in, .rstn_in, .pins(pins.host), .start_in, .op_in(op), .data_in(dat),
    .can_tx_in, .tx_request_in(tx_req), .dev_active_in(dev_act), .aux_o_in(ho), .aux_oe_in(hoe),
    .busy_out(busy), .done_out(done), .echo_ok_out(eok), .read_out(rd), .can_rx_out(crx));
  cxh_asserts i_chk (.clk_sys_in, .rstn_in, .port_select_n(pins.port_select_n), .sck(pins.sck),
    .sdo_oe(pins.sdo_oe));
  // ----------------
  // Pin resolution and clock
  // ----------------
  always @* for (int i = 0; i < 3; i++) if (pins.aux_dev_oe[i]) keep[i] = pins.aux_dev_o[i];
    else if (pins.aux_host_oe[i]) keep[i] = pins.aux_host_o[i];
  // Released aux pins show the inverse of their last level, so only a keeper can hold them.
  assign pins.aux_level = ~(keep ^ (pins.aux_dev_oe | pins.aux_host_oe));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  // ----------------
  // Tasks
  // ----------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic [7:0] o, input logic [7:0] d);
    int t;
    @(negedge clk_sys_in);
    op = o;
    dat = d;
    start_in = 1;
    @(negedge clk_sys_in);
    start_in = 0;
    t = 0;
    while (done !== 1'b1 && t < 400) begin
      @(negedge clk_sys_in);
      t++;
    end
    if (t == 400) fails++;
    chk(eok, 1);
    chk(lop, o);
    chk(ldat, d);
  endtask
  task settle;
    repeat (6) @(negedge clk_sys_in);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    repeat (16) @(negedge clk_sys_in);
    rstn_in = 1;
    settle();
    exp3 = {pins.port_select_n, pins.sck, pins.sdi};
    chk(skeep, exp3);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      xfer(8'h01, rnd[7:0]);
      xfer(8'h02, 8'h07);
      chk(pins.aux_dev_o, rnd[2:0]);
      chk(pins.aux_dev_oe, 3'h7);
    end
    mode = CXH_MODE_OTHER;
    settle();
    chk(pins.aux_dev_oe, 0);
    chk(pl, 1);
    chk(pu, 0);
    mode = CXH_MODE_NORMAL;
    sup = 0;
    settle();
    chk(pins.aux_dev_oe, 0);
    sup = 1;
    xfer(8'h02, 8'h00);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      if (i == 0) ho = rnd[2:0];
      hoe = (i == 0) ? 3'h7 : 3'h0;
      exp_q.push_back(ho);
      settle();
      xfer(8'h03, rnd[7:0]);
      chk(rd[2:0], exp_q.pop_front());
    end
    xfer(8'h04, 8'h01);
    xfer(8'h05, 8'h01);
    hoe = 3'h6;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      ho = rnd[2:0];
      bus_rx = rnd[3];
      settle();
      chk(tx2, ho[1]);
      chk(pins.aux_dev_o[0], bus_rx);
      chk(wake, ho[2]);
    end
    xfer(8'h04, 8'h00);
    hoe = 0;
    can_tx_in = 0;
    for (int m = 0; m < 8; m++) begin
      mode = cxh_mode_t'(m[2:1] ^ 2'h0);
      tx_req = m[0];
      settle();
      chk(pu, 1);
      chk(pl, 0);
      chk(tx_act, m[0] && (m < 2 || m > 5));
      chk(btx, (m[0] && (m < 2 || m > 5)) ? 0 : 1);
    end
    mode = CXH_MODE_NORMAL;
    dev_act = 0;
    settle();
    chk(pins.tx_enable_n, 1);
    dev_act = 1;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      can_tx_in = rnd[0];
      bus_rx = rnd[1];
      settle();
      chk(pins.txd, can_tx_in);
      chk(btx, can_tx_in);
      chk(crx, bus_rx);
    end
    exp3 = {pins.port_select_n, pins.sck, pins.sdi};
    sdrv = 0;
    op = 8'h05;
    dat = 8'hff;
    start_in = 1;
    @(negedge clk_sys_in);
    start_in = 0;
    repeat (40) @(negedge clk_sys_in);
    chk(skeep, exp3);
    while (busy) @(negedge clk_sys_in);
    settle();
    chk(lop, 8'h04);
    chk(ldat, 8'h00);
    final_report();
  end
endmodule // can_xcvr_host_pin_interface_tb
